//--- cps_defines.vh
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CPS_ADDR_STAT   12'h044
`define CPS_ADDR_TDC    12'h048
`define CPS_ADDR_IFLAG  12'h050
`define CPS_ADDR_IEN    12'h054
`define CPS_ADDR_ILS    12'h058
`define CPS_ADDR_ILE    12'h05c
`define CPS_ADDR_CTRL   12'h060
// ----------------------------------------
// error codes
// ----------------------------------------
`define CPS_EC_NONE     3'h0
`define CPS_EC_STUFF    3'h1
`define CPS_EC_FORM     3'h2
`define CPS_EC_ACK      3'h3
`define CPS_EC_BIT1     3'h4
`define CPS_EC_BIT0     3'h5
`define CPS_EC_CRC      3'h6
`define CPS_EC_NOCHG    3'h7
// ----------------------------------------
// activity codes
// ----------------------------------------
`define CPS_ACT_SYNC    2'h0
`define CPS_ACT_IDLE    2'h1
`define CPS_ACT_RX      2'h2
`define CPS_ACT_TX      2'h3
// ----------------------------------------
// status field positions
// ----------------------------------------
`define CPS_ST_DEC_LSB  8
`define CPS_ST_BO       7
`define CPS_ST_EW       6
`define CPS_ST_EP       5
`define CPS_ST_ACT_LSB  3
`define CPS_TDC_OFF_LSB 8
// ----------------------------------------
// interrupt flag bits
// ----------------------------------------
`define CPS_IF_ARA      29
`define CPS_IF_PED      28
`define CPS_IF_PEA      27
`define CPS_IF_WDI      26
`define CPS_IF_BO       25
`define CPS_IF_EW       24
`define CPS_IF_EP       23
`define CPS_IF_ELO      22
`define CPS_IF_BEU      21
`define CPS_IF_BEC      20
`define CPS_IF_DRX      19
`define CPS_IF_TOO      18
`define CPS_IF_MEMORY_ACCESS_FAILURE_FLAG     17
`define CPS_IF_MASK     32'h3ffe_0000
// ----------------------------------------
// control bits and limits
// ----------------------------------------
`define CPS_CTRL_INIT   0
`define CPS_CTRL_RESTR  1
`define CPS_WARN_LIMIT  8'h60
`define CPS_IDLE_SEQS   8'h81
`endif

//--- cps_status_irq.v
// How it works
// - data error code from switched-rate data phase
// - status byte 0 read sets data code 7
// - any status read sets arbitration code 7
// - bus-off, warning at 96, passive status bits
// - activity field encodes node state
// - protocol exception forces synchronizing activity
// - error-free frame clears arbitration code
// - codes 1-3: stuff, form, ack
// - codes 4-6: bit1, bit0, crc
// - recovery eleven-recessive writes bit0 code
// - data phase events go to data field
// - bus-off sets init; 129 idles after clear
// - counters reset after recovery; rec counts idles
// - offset field places secondary sample point
// - filter window active when above offset
// - flags edge-set, write one clears
// - protocol error flags on codes 1-6
// - flags on bus-off, warning, passive change
// - flags for misc events
// - memory bit-error flags; uncorrected sets init
// - receive access failure sets flag
// - transmit access failure: abort, restricted mode
// - flags gated by enable bits
// - line select and line enables
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cps_defines.vh"
module cps_status_irq #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              sys_rst,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire              pready,
  output reg  [31:0]       prdata,
  output wire              pslverr,
  // protocol engine events
  input  wire              err_valid,
  input  wire [2:0]        err_code,
  input  wire              frame_ok,
  input  wire              in_data_phase,
  input  wire              protocol_exception_event,
  input  wire [1:0]        node_activity,
  input  wire [7:0]        tx_err_count,
  input  wire [6:0]        receive_error_counter,
  input  wire              rx_passive,
  input  wire              bus_off_entry,
  input  wire              recessive_11,
  // other event sources
  input  wire              memory_watchdog_event,
  input  wire              error_log_overflow,
  input  wire              dedicated_buffer_store,
  input  wire              timeout_expired,
  input  wire [1:0]        msg_mem_bit_err,
  input  wire              rx_access_fail,
  input  wire              tx_access_fail,
  input  wire              reserved_access,
  // to protocol engine
  output wire [6:0]        ssp_offset,
  output wire [6:0]        ssp_filter_window,
  output wire              ssp_filter_on,
  output wire              init_active,
  output wire              restricted_operation_bit,
  output reg               recovery_active,
  output reg               err_counters_reset,
  output wire              recovery_count_pulse,
  output wire              tx_abort,
  output wire              rx_store_abort,
  // interrupt lines
  output reg               irq_line0,
  output reg               irq_line1
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;
  reg [31:0] stat_w;
  reg [31:0] tdc_q, iflag_q, ien_q, ils_q, ile_q;
  reg [1:0]  ctrl_q;
  reg [2:0]  arb_code_q, data_code_q;
  reg [7:0]  idle_cnt_q;
  reg        bo_q, ew_q, ep_q;
  reg [1:0]  be_prev_q;
  wire hit_stat = (paddr == `CPS_ADDR_STAT);
  wire hit_ctrl = (paddr == `CPS_ADDR_CTRL);
  wire mapped   = hit_stat | (paddr == `CPS_ADDR_TDC)
                | (paddr == `CPS_ADDR_IFLAG) | (paddr == `CPS_ADDR_IEN)
                | (paddr == `CPS_ADDR_ILS) | (paddr == `CPS_ADDR_ILE)
                | hit_ctrl;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
  function bad_code;
    input [2:0] c;
    begin
      bad_code = (c != `CPS_EC_NONE) && (c != `CPS_EC_NOCHG);
    end
  endfunction
  // ----------------------------------------
  // live status bits
  // ----------------------------------------
  wire warn_now = (tx_err_count >= `CPS_WARN_LIMIT)
                | ({1'b0, receive_error_counter} >= `CPS_WARN_LIMIT);
  wire ep_now = rx_passive | tx_err_count[7];
  wire [1:0] act_now = protocol_exception_event ? `CPS_ACT_SYNC
                     : node_activity;
  // ----------------------------------------
  // bus-off recovery
  // ----------------------------------------
  wire recovering = bo_q & ~ctrl_q[`CPS_CTRL_INIT];
  wire recovery_done = recovering & recessive_11
                     & (idle_cnt_q == `CPS_IDLE_SEQS - 8'h01);
  assign recovery_count_pulse = recovering & recessive_11;
  // bus-off holds until the last counted idle sequence
  wire bo_now = bus_off_entry | bo_q & ~recovery_done;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      bo_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      recovery_active <= 1'b0;
      err_counters_reset <= 1'b0;
    end else begin
      bo_q <= bo_now;
      recovery_active <= recovering;
      err_counters_reset <= recovery_done;
      // init toggling does not restart the count
      if (recovery_done | ~bo_q)
        idle_cnt_q <= 8'h00;
      else if (recovery_count_pulse)
        idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end
  // ----------------------------------------
  // error codes
  // ----------------------------------------
  wire rd_stat = rd & hit_stat;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      arb_code_q <= `CPS_EC_NOCHG;
      data_code_q <= `CPS_EC_NOCHG;
    end else begin
      if (rd_stat)
        arb_code_q <= `CPS_EC_NOCHG;
      if (rd_stat & pstrb[0])
        data_code_q <= `CPS_EC_NOCHG;
      // engine reports codes 1..6 per the codings; hardware beats read
      if (recovery_count_pulse)
        arb_code_q <= `CPS_EC_BIT0;
      else if (in_data_phase) begin
        if (err_valid)
          data_code_q <= err_code;
        else if (frame_ok)
          data_code_q <= `CPS_EC_NONE;
      end else begin
        if (err_valid)
          arb_code_q <= err_code;
        else if (frame_ok)
          arb_code_q <= `CPS_EC_NONE;
      end
    end
  end
  // ----------------------------------------
  // control: init and restricted mode
  // ----------------------------------------
  wire ctrl_wr = wr & hit_ctrl & pstrb[0];
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= 2'b01;
    end else begin
      if (ctrl_wr)
        ctrl_q <= pwdata[1:0];
      if (bus_off_entry | msg_mem_bit_err[1])
        ctrl_q[`CPS_CTRL_INIT] <= 1'b1;
      if (tx_access_fail)
        ctrl_q[`CPS_CTRL_RESTR] <= 1'b1;
    end
  end
  assign init_active = ctrl_q[`CPS_CTRL_INIT];
  assign restricted_operation_bit = ctrl_q[`CPS_CTRL_RESTR];
  assign tx_abort = tx_access_fail;
  // put index and new data stay put when this is high
  assign rx_store_abort = rx_access_fail;
  // ----------------------------------------
  // delay compensation config
  // ----------------------------------------
  assign ssp_offset = tdc_q[`CPS_TDC_OFF_LSB +: 7];
  assign ssp_filter_window = tdc_q[6:0];
  assign ssp_filter_on = (ssp_filter_window > ssp_offset);
  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  reg [31:0] ev;
  always @* begin
    ev = 32'h0000_0000;
    ev[`CPS_IF_ARA]  = reserved_access | pslverr;
    ev[`CPS_IF_PED]  = in_data_phase & err_valid & bad_code(err_code);
    ev[`CPS_IF_PEA]  = ~in_data_phase & err_valid & bad_code(err_code);
    ev[`CPS_IF_WDI]  = memory_watchdog_event;
    ev[`CPS_IF_BO]   = bo_now ^ bo_q;
    ev[`CPS_IF_EW]   = warn_now ^ ew_q;
    ev[`CPS_IF_EP]   = ep_now ^ ep_q;
    ev[`CPS_IF_ELO]  = error_log_overflow;
    ev[`CPS_IF_BEU]  = msg_mem_bit_err[1] & ~be_prev_q[1];
    ev[`CPS_IF_BEC]  = msg_mem_bit_err[0] & ~be_prev_q[0];
    ev[`CPS_IF_DRX]  = dedicated_buffer_store;
    ev[`CPS_IF_TOO]  = timeout_expired;
    ev[`CPS_IF_MEMORY_ACCESS_FAILURE_FLAG] = rx_access_fail | tx_access_fail;
  end
  wire [31:0] clr = (wr && paddr == `CPS_ADDR_IFLAG)
                  ? wmerge(32'h0000_0000, pwdata, pstrb) : 32'h0000_0000;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      iflag_q <= 32'h0000_0000;
      ew_q <= 1'b0;
      ep_q <= 1'b0;
      be_prev_q <= 2'b00;
    end else begin
      // a new event beats a clear in the same cycle
      iflag_q <= ((iflag_q & ~clr) | ev) & `CPS_IF_MASK;
      ew_q <= warn_now;
      ep_q <= ep_now;
      be_prev_q <= msg_mem_bit_err;
    end
  end
  // ----------------------------------------
  // config registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tdc_q <= 32'h0000_0000;
      ien_q <= 32'h0000_0000;
      ils_q <= 32'h0000_0000;
      ile_q <= 32'h0000_0000;
    end else if (wr) begin
      case (paddr)
        `CPS_ADDR_TDC:
          tdc_q <= wmerge(tdc_q, pwdata, pstrb) & 32'h0000_7f7f;
        `CPS_ADDR_IEN:
          ien_q <= wmerge(ien_q, pwdata, pstrb) & `CPS_IF_MASK;
        `CPS_ADDR_ILS:
          ils_q <= wmerge(ils_q, pwdata, pstrb) & `CPS_IF_MASK;
        `CPS_ADDR_ILE:
          ile_q <= wmerge(ile_q, pwdata, pstrb) & 32'h0000_0003;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // interrupt lines
  // ----------------------------------------
  wire [31:0] pend = iflag_q & ien_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_line0 <= 1'b0;
      irq_line1 <= 1'b0;
    end else begin
      irq_line0 <= ile_q[0] & |(pend & ~ils_q);
      irq_line1 <= ile_q[1] & |(pend & ils_q);
    end
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    stat_w = 32'h0000_0000;
    stat_w[2:0] = arb_code_q;
    stat_w[`CPS_ST_ACT_LSB +: 2] = act_now;
    stat_w[`CPS_ST_EP] = ep_q;
    stat_w[`CPS_ST_EW] = ew_q;
    stat_w[`CPS_ST_BO] = bo_q;
    stat_w[`CPS_ST_DEC_LSB +: 3] = data_code_q;
    case (paddr)
      `CPS_ADDR_STAT:  prdata = stat_w;
      `CPS_ADDR_TDC:   prdata = tdc_q;
      `CPS_ADDR_IFLAG: prdata = iflag_q;
      `CPS_ADDR_IEN:   prdata = ien_q;
      `CPS_ADDR_ILS:   prdata = ils_q;
      `CPS_ADDR_ILE:   prdata = ile_q;
      `CPS_ADDR_CTRL:  prdata = {30'h0000_0000, ctrl_q};
      default:         prdata = 32'h0000_0000;
    endcase
  end
endmodule // cps_status_irq
`default_nettype wire

//--- cps_status_irq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cps_status_irq_asserts (
  // clock and bus
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // engine side
  input wire logic        protocol_exception_event,
  input wire logic [7:0]  tx_err_count,
  input wire logic [6:0]  receive_error_counter,
  input wire logic        bus_off_entry,
  input wire logic [1:0]  msg_mem_bit_err,
  input wire logic        tx_access_fail,
  input wire logic        rx_access_fail,
  input wire logic        init_active,
  input wire logic        restricted_operation_bit,
  input wire logic        tx_abort,
  input wire logic        rx_store_abort,
  input wire logic [6:0]  ssp_offset,
  input wire logic [6:0]  ssp_filter_window,
  input wire logic        ssp_filter_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire rd_st;
  assign rd_st = psel && !pwrite && paddr == 12'h044;
  property p_map; psel && penable |-> pslverr == !(paddr inside {12'h044,
    12'h048, 12'h050, 12'h054, 12'h058, 12'h05c, 12'h060}); endproperty
  a_map: assert property (p_map) else $error("bad slave error");
  // the exception must win even while a read is under way
  property p_act; rd_st && protocol_exception_event &&
    $past(protocol_exception_event) |-> prdata[4:3] == 2'h0; endproperty
  a_act: assert property (p_act) else $error("activity not sync");
  property p_warn; rd_st && $stable(tx_err_count) &&
    $stable(receive_error_counter) |-> prdata[6] ==
    (tx_err_count >= 8'h60 || receive_error_counter >= 7'h60); endproperty
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  property p_boi; bus_off_entry |-> ##[1:2] init_active; endproperty
  a_boi: assert property (p_boi) else $error("no init on bus-off");
  property p_beu; $rose(msg_mem_bit_err[1]) |-> ##[1:2] init_active;
  endproperty
  a_beu: assert property (p_beu) else $error("no init on bit error");
  property p_tx; tx_access_fail |-> tx_abort ##[1:2] restricted_operation_bit;
  endproperty
  a_tx: assert property (p_tx) else $error("tx failure ignored");
  property p_rx; rx_access_fail |-> rx_store_abort; endproperty
  a_rx: assert property (p_rx) else $error("rx store not aborted");
  property p_flt; ssp_filter_on == (ssp_filter_window > ssp_offset);
  endproperty
  a_flt: assert property (p_flt) else $error("filter enable wrong");
endmodule // cps_status_irq_asserts
`default_nettype wire

//--- cps_can_node.sv
`timescale 1ns/10ps
`default_nettype none
module cps_can_node (
  // clock
  input  wire logic       core_clk,
  // bus events as the engine reports them
  output var  logic       err_valid,
  output var  logic [2:0] err_code,
  output var  logic       frame_ok,
  output var  logic       in_data_phase,
  output var  logic       protocol_exception_event,
  output var  logic [1:0] node_activity,
  output var  logic [7:0] tx_err_count,
  output var  logic [6:0] receive_error_counter,
  output var  logic       rx_passive,
  output var  logic       bus_off_entry,
  output var  logic       recessive_11
);
  initial begin
    {err_valid, err_code, frame_ok, in_data_phase, protocol_exception_event,
     tx_err_count, receive_error_counter, rx_passive, bus_off_entry,
     recessive_11} = '0;
    node_activity = 2'h1;
  end
  // one frame outcome; code is scrambled once the pulse is over
  task automatic ev(input logic [2:0] c, input logic dp, input logic ok);
    @(posedge core_clk);
    err_valid     <= !ok;
    err_code      <= c;
    frame_ok      <= ok;
    in_data_phase <= dp;
    @(posedge core_clk);
    err_valid     <= 1'b0;
    err_code      <= ~c;
    frame_ok      <= 1'b0;
    in_data_phase <= 1'b0;
  endtask
  task automatic boff;
    @(posedge core_clk);
    bus_off_entry <= 1'b1;
    @(posedge core_clk);
    bus_off_entry <= 1'b0;
  endtask
  // real idle runs are 11 bit times; compressed to keep the run short
  task automatic idles(input int n);
    repeat (n) begin
      @(posedge core_clk);
      recessive_11 <= 1'b1;
      @(posedge core_clk);
      recessive_11 <= 1'b0;
    end
  endtask
endmodule // cps_can_node
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        core_clk, sys_rst, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  pstrb;
  logic [8:0]  ev;
  wire  [31:0] prdata;
  wire  [7:0]  tx_err_count;
  wire  [6:0]  ssp_offset, ssp_filter_window, receive_error_counter;
  wire  [2:0]  err_code;
  wire  [1:0]  node_activity, msg_mem_bit_err;
  wire pready, pslverr, ssp_filter_on, init_active, restricted_operation_bit,
    recovery_active, err_counters_reset, recovery_count_pulse, tx_abort,
    rx_store_abort, irq_line0, irq_line1, err_valid, frame_ok, in_data_phase,
    protocol_exception_event, rx_passive, bus_off_entry, recessive_11,
    memory_watchdog_event, error_log_overflow, dedicated_buffer_store,
    timeout_expired, rx_access_fail, tx_access_fail, reserved_access;
  int checks, fail_count, cyc;
  int fb[9] = '{29, 26, 22, 20, 21, 19, 18, 17, 17};
  assign {tx_access_fail, rx_access_fail, timeout_expired,
    dedicated_buffer_store, msg_mem_bit_err, error_log_overflow,
    memory_watchdog_event, reserved_access} = ev;
  cps_status_irq dut (.*);
  cps_can_node u_node (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  // idle edge before each setup: no signal is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rs(input logic [3:0] s);
    apb(1'b0, 12'h044, 32'h0, s);
  endtask
  task automatic rf;
    apb(1'b0, 12'h050, 32'h0, 4'hf);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic t_codes;
    rs(4'h0);
    chk(rd[10:0], 11'h70f);
    rf;
    chk(rd, 32'h0);
    for (int c = 1; c < 7; c++) begin
      u_node.ev(c[2:0], 1'b0, 1'b0);
      rs(4'h0);
      chk(rd[2:0], c);
      rf;
      chk(rd[27], 1'b1);
      wr(12'h050, 32'h0800_0000);
      rf;
      chk(rd[27], 1'b0);
    end
    u_node.ev(3'h0, 1'b0, 1'b1);
    rs(4'h0);
    chk(rd[2:0], 3'h0);
    rs(4'h0);
    chk(rd[2:0], 3'h7);
    rf;
    chk(rd[27], 1'b0);
  endtask
  task automatic t_data;
    u_node.ev(3'h6, 1'b1, 1'b0);
    rs(4'h0);
    chk(rd[10:0], 11'h60f);
    rs(4'h0);
    chk(rd[10:8], 3'h6);
    rf;
    chk(rd[28], 1'b1);
    rs(4'hf);
    rs(4'h0);
    chk(rd[10:8], 3'h7);
    u_node.ev(3'h0, 1'b1, 1'b1);
    rs(4'h0);
    chk(rd[10:8], 3'h0);
  endtask
  task automatic t_state;
    wr(12'h050, 32'hffff_ffff);
    u_node.tx_err_count <= 8'h5f;
    rs(4'h0);
    chk(rd[6], 1'b0);
    for (int a = 0; a < 4; a++) begin
      u_node.node_activity <= a[1:0];
      rs(4'h0);
      chk(rd[4:3], a);
    end
    u_node.tx_err_count <= 8'h60;
    u_node.rx_passive <= 1'b1;
    rs(4'h0);
    chk(rd[6:5], 2'h3);
    rf;
    chk(rd[24:23], 2'h3);
    u_node.protocol_exception_event <= 1'b1;
    repeat (2) @(posedge core_clk);
    rs(4'h0);
    chk(rd[4:3], 2'h0);
    u_node.protocol_exception_event <= 1'b0;
    u_node.tx_err_count <= 8'h0;
    u_node.rx_passive <= 1'b0;
  endtask
  task automatic t_tdc;
    wr(12'h048, 32'h0000_107f);
    apb(1'b0, 12'h048, 32'h0, 4'hf);
    chk(rd, 32'h0000_107f);
    chk({ssp_offset, ssp_filter_window, ssp_filter_on}, 15'h10ff);
    wr(12'h048, 32'h0000_7f7f);
    @(posedge core_clk);
    chk({ssp_offset, ssp_filter_window, ssp_filter_on}, 15'h7ffe);
  endtask
  task automatic t_busoff;
    wr(12'h060, 32'h0);
    u_node.boff;
    @(posedge core_clk);
    chk(init_active, 1'b1);
    rs(4'h0);
    chk(rd[7], 1'b1);
    wr(12'h060, 32'h0);
    u_node.idles(64);
    wr(12'h060, 32'h1);
    wr(12'h060, 32'h0);
    u_node.idles(64);
    rs(4'h0);
    chk({recovery_active, rd[2:0]}, 4'hd);
    u_node.idles(1);
    rs(4'h0);
    chk({recovery_active, rd[7]}, 2'h0);
  endtask
  task automatic t_irq;
    wr(12'h050, 32'hffff_ffff);
    wr(12'h054, 32'h2000_0000);
    wr(12'h058, 32'h2000_0000);
    wr(12'h05c, 32'h0000_0003);
    apb(1'b0, 12'h070, 32'h0, 4'hf);
    chk({err, rd}, 33'h1_0000_0000);
    repeat (2) @(posedge core_clk);
    chk({irq_line1, irq_line0}, 2'h2);
    wr(12'h05c, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk({irq_line1, irq_line0}, 2'h0);
    wr(12'h05c, 32'h0000_0003);
    wr(12'h054, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({irq_line1, irq_line0}, 2'h0);
  endtask
  task automatic t_events;
    for (int i = 0; i < 9; i++) begin
      wr(12'h050, 32'hffff_ffff);
      ev <= 9'h1 << i;
      @(posedge core_clk);
      ev <= 9'h0;
      wr(12'h050, 32'h0);
      rf;
      chk(rd & 32'h3ffe_0000, 32'h1 << fb[i]);
      wr(12'h050, 32'h1 << fb[i]);
      rf;
      chk(rd & 32'h3ffe_0000, 32'h0);
    end
    chk({init_active, restricted_operation_bit}, 2'h3);
  endtask
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, ev} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_codes;
    t_data;
    t_state;
    t_tdc;
    t_busoff;
    t_irq;
    t_events;
    wrap_up;
  end
endmodule // tb_top
bind cps_status_irq cps_status_irq_asserts u_chk (.*);
`default_nettype wire
